// file: logic/pfs_pkg.sv
package pfs_pkg;

  // Configuration offsets of the two registers.
  localparam logic [7:0] PFS_STATUS_OFF = 8'h06;
  localparam logic [7:0] PFS_REVISION_OFF = 8'h08;

  // Status reset value and hardwired field values.
  localparam logic [15:0] PFS_STATUS_RESET = 16'h0210;
  localparam logic [1:0] PFS_SELECT_TIMING = 2'h1;
  localparam logic PFS_CAP_LIST_VALUE = 1'h1;
  localparam logic PFS_ZERO_BIT = 1'h0;

  // Bit positions inside the status word.
  localparam int PFS_DETECTED_PARITY_BIT = 15;
  localparam int PFS_SIGNALED_SYSERR_BIT = 14;
  localparam int PFS_MASTER_ABORT_BIT = 13;
  localparam int PFS_TARGET_ABORT_RCVD_BIT = 12;
  localparam int PFS_TARGET_ABORT_SIG_BIT = 11;
  localparam int PFS_SELECT_TIMING_HI = 10;
  localparam int PFS_SELECT_TIMING_LO = 9;
  localparam int PFS_MASTER_DATA_PARITY_BIT = 8;
  localparam int PFS_BACK_TO_BACK_BIT = 7;
  localparam int PFS_USER_FEATURE_BIT = 6;
  localparam int PFS_HIGH_SPEED_BIT = 5;
  localparam int PFS_CAP_LIST_BIT = 4;
  localparam int PFS_INT_STATUS_BIT = 3;

  // Index of each error flag inside the packed flag vector.
  localparam int PFS_NUM_FLAGS = 6;
  localparam int PFS_F_PARITY = 0;
  localparam int PFS_F_SYSERR = 1;
  localparam int PFS_F_RECEIVED_MASTER_ABORT_FLAG = 2;
  localparam int PFS_F_TABORT_RCVD = 3;
  localparam int PFS_F_TABORT_SIG = 4;
  localparam int PFS_F_DATA_PARITY = 5;

  typedef logic [PFS_NUM_FLAGS-1:0] pfs_flags_t;

  // Pull the write-one-to-clear bits out of a status write.
  function automatic pfs_flags_t pfs_err_bits(input logic [15:0] w);
    pfs_flags_t f;
    f = '0;
    f[PFS_F_PARITY] = w[PFS_DETECTED_PARITY_BIT];
    f[PFS_F_SYSERR] = w[PFS_SIGNALED_SYSERR_BIT];
    f[PFS_F_RECEIVED_MASTER_ABORT_FLAG] = w[PFS_MASTER_ABORT_BIT];
    f[PFS_F_TABORT_RCVD] = w[PFS_TARGET_ABORT_RCVD_BIT];
    f[PFS_F_TABORT_SIG] = w[PFS_TARGET_ABORT_SIG_BIT];
    f[PFS_F_DATA_PARITY] = w[PFS_MASTER_DATA_PARITY_BIT];
    return f;
  endfunction

  // Build the status word from flags, interrupt state and constants.
  function automatic logic [15:0] pfs_compose(input pfs_flags_t f,
                                              input logic int_st);
    logic [15:0] s;
    s = '0;
    s[PFS_DETECTED_PARITY_BIT] = f[PFS_F_PARITY];
    s[PFS_SIGNALED_SYSERR_BIT] = f[PFS_F_SYSERR];
    s[PFS_MASTER_ABORT_BIT] = f[PFS_F_RECEIVED_MASTER_ABORT_FLAG];
    s[PFS_TARGET_ABORT_RCVD_BIT] = f[PFS_F_TABORT_RCVD];
    s[PFS_TARGET_ABORT_SIG_BIT] = f[PFS_F_TABORT_SIG];
    s[PFS_SELECT_TIMING_HI:PFS_SELECT_TIMING_LO] = PFS_SELECT_TIMING;
    s[PFS_MASTER_DATA_PARITY_BIT] = f[PFS_F_DATA_PARITY];
    s[PFS_BACK_TO_BACK_BIT] = PFS_ZERO_BIT;
    s[PFS_USER_FEATURE_BIT] = PFS_ZERO_BIT;
    s[PFS_HIGH_SPEED_BIT] = PFS_ZERO_BIT;
    s[PFS_CAP_LIST_BIT] = PFS_CAP_LIST_VALUE;
    s[PFS_INT_STATUS_BIT] = int_st;
    return s;
  endfunction

endpackage

// file: logic/pfs_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Sticky error flags and interrupt status of one function.
module pfs_flag_bank (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire pfs_pkg::pfs_flags_t set_in,
  input wire pfs_pkg::pfs_flags_t clr_in,
  input wire logic int_cond_in,
  output pfs_pkg::pfs_flags_t flags_out,
  output logic int_status_out
);
  import pfs_pkg::*;

  typedef struct packed {
    pfs_flags_t flags;
    logic int_st;
  } pfs_bank_t;

  pfs_bank_t bank_r;
  pfs_bank_t bank_nxt;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    bank_nxt = bank_r;
    bank_nxt.flags = (bank_r.flags & ~clr_in) | set_in;
    bank_nxt.int_st = int_cond_in;
  end

  // Of the resets, only the global reset clears the flags; no soft reset reaches here.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bank_r <= '0;
    end else begin
      bank_r <= bank_nxt;
    end
  end

  assign flags_out = bank_r.flags;
  assign int_status_out = bank_r.int_st;

endmodule // pfs_flag_bank
`default_nettype wire

// file: logic/pfs_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Per-function status and revision registers in configuration space.
module pfs_status_regs #(
  parameter int NUM_FUNC = 2,
  // Arbitrary revision value; set per silicon step.
  parameter logic [7:0] REVISION_CODE = 8'h5A,
  localparam int FUNC_W = (NUM_FUNC > 1) ? $clog2(NUM_FUNC) : 1
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_wr_in,
  input wire logic [FUNC_W-1:0] cfg_func_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [1:0] cfg_be_in,
  input wire logic [15:0] cfg_wdata_in,
  input wire logic [NUM_FUNC-1:0] int_mask_in,
  input wire logic [NUM_FUNC-1:0] system_error_report_enable_in,
  input wire logic [NUM_FUNC-1:0] parity_response_enable_in,
  input wire logic [NUM_FUNC-1:0] int_cond_in,
  input wire logic addr_parity_err_in,
  input wire logic data_parity_err_in,
  input wire logic perr_seen_in,
  input wire logic bus_master_in,
  input wire logic [FUNC_W-1:0] master_func_in,
  input wire logic [FUNC_W-1:0] target_func_in,
  input wire logic master_abort_in,
  input wire logic target_abort_rcvd_in,
  input wire logic target_abort_sig_in,
  output logic [15:0] cfg_rdata_out,
  output logic cfg_ack_out,
  output logic serr_out,
  output logic [NUM_FUNC-1:0] intx_out
);
  import pfs_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
    logic ack;
    logic serr;
    logic [NUM_FUNC-1:0] intx;
  } pfs_top_t;

  pfs_top_t top_r;
  pfs_top_t top_nxt;

  pfs_flags_t set_v [NUM_FUNC];
  pfs_flags_t clr_v [NUM_FUNC];
  pfs_flags_t flags_v [NUM_FUNC];
  logic [NUM_FUNC-1:0] int_st_v;
  logic serr_fire;
  logic wr_status;
  logic [15:0] wmask;

  // The enables are wired-OR across functions, so any function that has
  // both bits set lets an address parity error drive the error line.
  assign serr_fire = addr_parity_err_in &
    (|(system_error_report_enable_in & parity_response_enable_in));

  // Byte enables gate the write so an untouched lane never clears flags.
  assign wr_status = cfg_wr_in && (cfg_addr_in == PFS_STATUS_OFF);
  assign wmask = cfg_wdata_in & {{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};

  // Each function gets its own flag bank fed by the shared bus events.
  for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
    localparam logic [FUNC_W-1:0] FID = FUNC_W'(f);
    logic is_master;
    logic is_target;

    assign is_master = (master_func_in == FID);
    assign is_target = (target_func_in == FID);

    // Events that set this function's flags.
    always_comb begin
      set_v[f] = '0;
      set_v[f][PFS_F_PARITY] = addr_parity_err_in |
                               data_parity_err_in;
      set_v[f][PFS_F_SYSERR] = serr_fire &
                               system_error_report_enable_in[f];
      set_v[f][PFS_F_RECEIVED_MASTER_ABORT_FLAG] = master_abort_in & is_master;
      set_v[f][PFS_F_TABORT_RCVD] = target_abort_rcvd_in &
                                    is_master;
      set_v[f][PFS_F_TABORT_SIG] = target_abort_sig_in & is_target;
      set_v[f][PFS_F_DATA_PARITY] = data_parity_err_in & perr_seen_in &
                                    bus_master_in & is_master &
                                    parity_response_enable_in[f];
    end

    // Only flag positions are cleared; hardwired bits ignore the write.
    assign clr_v[f] = (wr_status && cfg_func_in == FID) ?
                      pfs_err_bits(wmask) : '0;

    pfs_flag_bank u_bank (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .set_in(set_v[f]),
      .clr_in(clr_v[f]),
      .int_cond_in(int_cond_in[f]),
      .flags_out(flags_v[f]),
      .int_status_out(int_st_v[f])
    );
  end

  // Read data, error line and interrupt lines all come from flops.
  // Reads have no side effects; unknown offsets return zero.
  always_comb begin
    top_nxt = top_r;
    top_nxt.ack = cfg_rd_in;
    top_nxt.serr = serr_fire;
    top_nxt.intx = int_st_v & ~int_mask_in;
    if (cfg_rd_in) begin
      top_nxt.rdata = '0;
      for (int i = 0; i < NUM_FUNC; i++) begin
        if (cfg_func_in == FUNC_W'(i)) begin
          if (cfg_addr_in == PFS_STATUS_OFF) begin
            top_nxt.rdata = pfs_compose(flags_v[i], int_st_v[i]);
          end else if (cfg_addr_in == PFS_REVISION_OFF) begin
            top_nxt.rdata = {8'h00, REVISION_CODE};
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      top_r <= '0;
    end else begin
      top_r <= top_nxt;
    end
  end

  assign cfg_rdata_out = top_r.rdata;
  assign cfg_ack_out = top_r.ack;
  assign serr_out = top_r.serr;
  assign intx_out = top_r.intx;

endmodule // pfs_status_regs
`default_nettype wire

// file: tb/pfs_status_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks of the status block; one clock, one reset.
module pfs_status_chk #(
  parameter int NUM_FUNC = 2,
  parameter logic [7:0] REVISION_CODE = 8'h5A
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [NUM_FUNC-1:0] int_mask_in,
  input wire logic [NUM_FUNC-1:0] system_error_report_enable_in,
  input wire logic [NUM_FUNC-1:0] parity_response_enable_in,
  input wire logic [NUM_FUNC-1:0] int_cond_in,
  input wire logic addr_parity_err_in,
  input wire logic [15:0] cfg_rdata_out,
  input wire logic cfg_ack_out,
  input wire logic serr_out,
  input wire logic [NUM_FUNC-1:0] intx_out
);
  import pfs_pkg::*;
  logic serr_qual;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Enables are wired-OR across functions for the request line.
  assign serr_qual = addr_parity_err_in &&
    |(system_error_report_enable_in & parity_response_enable_in);
  // A status read; its answer lands one edge later.
  sequence st_rd;
    cfg_rd_in && cfg_addr_in == 8'h06;
  endsequence
  AST_ACK: assert property (cfg_rd_in |=> cfg_ack_out)
    else $error("read not answered");
  AST_FIXED: assert property (st_rd |=>
    (cfg_rdata_out & 16'h06F7) == 16'h0210) else $error("fixed bits");
  AST_REV: assert property (cfg_rd_in && cfg_addr_in == 8'h08 |=>
    cfg_rdata_out == {8'h00, REVISION_CODE}) else $error("revision");
  AST_PARITY: assert property (addr_parity_err_in ##1 st_rd |=>
    cfg_rdata_out[15]) else $error("parity flag missing");
  AST_SERR: assert property (serr_qual |=> serr_out)
    else $error("serr missing");
  AST_NO_SERR: assert property (!serr_qual |=> !serr_out)
    else $error("serr unexpected");
  AST_MASK: assert property (int_mask_in[0] |=> !intx_out[0])
    else $error("masked intx");
  AST_INTX: assert property (int_cond_in[0] ##1 !int_mask_in[0] |=>
    intx_out[0]) else $error("intx missing");
endmodule // pfs_status_chk
bind pfs_status_regs pfs_status_chk #(
  .NUM_FUNC(NUM_FUNC), .REVISION_CODE(REVISION_CODE)) i_chk (
  .core_clk_in, .rst_b_in, .cfg_rd_in, .cfg_addr_in, .int_mask_in,
  .system_error_report_enable_in, .parity_response_enable_in,
  .int_cond_in, .addr_parity_err_in, .cfg_rdata_out, .cfg_ack_out,
  .serr_out, .intx_out);
`default_nettype wire

// file: tb/pfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Command bits that configuration software keeps per function.
module pfs_host_model (
  input wire logic core_clk_in,
  output logic [1:0] msk_out,
  output logic [1:0] sen_out,
  output logic [1:0] pen_out
);
  initial {msk_out, sen_out, pen_out} = '0;
  // Changes land on a falling edge, clear of sampling.
  task automatic set_cmd(input logic f, m, s, p);
    @(negedge core_clk_in);
    {msk_out[f], sen_out[f], pen_out[f]} = {m, s, p};
  endtask
endmodule // pfs_host_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pfs_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value.
  localparam logic [7:0] ST = PFS_STATUS_OFF;
  logic clk, rst_b, rd, wr, fn, bm, mf, tf, ack, serr, g_ack, g_serr;
  logic [7:0] addr;
  logic [1:0] be, msk, sen, pen, ic, intx;
  logic [15:0] wd, rdat, got;
  logic [5:0] ev;
  int n_errors, tests_run;
  pfs_status_regs #(.NUM_FUNC(2), .REVISION_CODE(REV)) i_dut (
    .core_clk_in(clk), .rst_b_in(rst_b), .cfg_rd_in(rd), .cfg_wr_in(wr),
    .cfg_func_in(fn), .cfg_addr_in(addr), .cfg_be_in(be),
    .cfg_wdata_in(wd), .int_mask_in(msk), .int_cond_in(ic),
    .system_error_report_enable_in(sen), .parity_response_enable_in(pen),
    .addr_parity_err_in(ev[5]), .data_parity_err_in(ev[4]),
    .perr_seen_in(ev[3]), .bus_master_in(bm), .master_func_in(mf),
    .target_func_in(tf), .master_abort_in(ev[2]),
    .target_abort_rcvd_in(ev[1]), .target_abort_sig_in(ev[0]),
    .cfg_rdata_out(rdat), .cfg_ack_out(ack), .serr_out(serr),
    .intx_out(intx));
  pfs_host_model i_host (.core_clk_in(clk), .msk_out(msk),
    .sen_out(sen), .pen_out(pen));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobe for one edge, then idle a cycle so strobes never retoggle.
  task automatic acc(input logic w, f, input logic [7:0] a,
                     input logic [1:0] b, input logic [15:0] d);
    {wr, rd, fn, addr, be, wd} = {w, !w, f, a, b, d};
    @(negedge clk);
    {g_ack, got} = {ack, rdat};
    {wr, rd} = 2'h0;
    @(negedge clk);
  endtask
  task automatic rdc(input logic f, input logic [7:0] a,
                     input logic [15:0] e);
    acc(0, f, a, 2'h3, 16'h0);
    chk("ack", {15'h0, g_ack}, 16'h1);
    chk("rdata", got, e);
  endtask
  // Events stand for one edge; the error line is caught while it stands.
  // No idle cycle follows, so a read can land on the very next edge.
  task automatic pulse(input logic [5:0] e);
    ev = e;
    @(negedge clk);
    g_serr = serr;
    ev = '0;
  endtask
  task automatic clr;
    acc(1, 0, ST, 2'h3, 16'hFFFF);
    acc(1, 1, ST, 2'h3, 16'hFFFF);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // The sequence needs about 110 cycles; far beyond that is a hang.
  initial begin
    #20000;
    n_errors++;
    give_verdict;
  end
  initial begin
    {rd, wr, fn, bm, mf, tf, addr, be, wd, ic, ev} = '0;
    {rst_b, n_errors, tests_run} = '0;
    repeat (20) @(negedge clk);
    rst_b = 1;
    rdc(1, ST, PFS_STATUS_RESET);
    acc(1, 0, PFS_REVISION_OFF, 2'h3, 16'hFFFF);
    rdc(0, PFS_REVISION_OFF, {8'h00, REV});
    rdc(0, 8'h10, 16'h0);
    acc(1, 0, ST, 2'h3, 16'hFFFF);
    rdc(0, ST, PFS_STATUS_RESET);
    mf = 1;
    pulse(6'h04);
    rdc(1, ST, 16'h2210);
    rdc(0, ST, 16'h0210);
    mf = 0;
    pulse(6'h02);
    acc(1, 0, ST, 2'h1, 16'hFFFF);
    rdc(0, ST, 16'h1210);
    acc(1, 0, ST, 2'h2, 16'h0000);
    rdc(0, ST, 16'h1210);
    acc(1, 0, ST, 2'h2, 16'h1000);
    rdc(0, ST, 16'h0210);
    tf = 1;
    pulse(6'h01);
    rdc(1, ST, 16'h2A10);
    clr;
    rdc(1, ST, 16'h0210);
    i_host.set_cmd(0, 0, 0, 1);
    bm = 1;
    pulse(6'h18);
    rdc(0, ST, 16'h8310);
    rdc(1, ST, 16'h8210);
    clr;
    bm = 0;
    pulse(6'h18);
    rdc(0, ST, 16'h8210);
    clr;
    i_host.set_cmd(1, 0, 1, 1);
    pulse(6'h20);
    chk("serr", {15'h0, g_serr}, 16'h1);
    rdc(1, ST, 16'hC210);
    rdc(0, ST, 16'h8210);
    clr;
    i_host.set_cmd(1, 0, 1, 0);
    i_host.set_cmd(0, 0, 0, 0);
    pulse(6'h20);
    chk("serr", {15'h0, g_serr}, 16'h0);
    rdc(1, ST, 16'h8210);
    clr;
    ic = 2'h1;
    repeat (3) @(negedge clk);
    chk("intx", {14'h0, intx}, 16'h1);
    i_host.set_cmd(0, 1, 0, 0);
    repeat (2) @(negedge clk);
    chk("intx", {14'h0, intx}, 16'h0);
    rdc(0, ST, 16'h0218);
    ic = 2'h0;
    pulse(6'h20);
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    rdc(0, ST, PFS_STATUS_RESET);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
